// *** src/addr_data_pin_function_mux.sv ***
// pin function mux for the shared port b line and four shared data pins
//
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "pin_mux_defines.svh"

module addr_data_pin_function_mux (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  srst,
  // register bus
  input  wire pin_mux_pkg::avm_req_t avm_req,
  output pin_mux_pkg::avm_rsp_t      avm_rsp,
  // shared port b pin
  input  wire logic                  portb_line_four_in,
  output pin_mux_pkg::pad_t          portb_line_four_pad,
  // shared data / port f pins
  input  wire logic [3:0]            portf_in,
  output pin_mux_pkg::pad_t [3:0]    portf_pad,
  // external memory logic and clock prescaler
  input  wire pin_mux_pkg::mem_bus_t mem_bus,
  output logic [3:0]                 dbus_in,
  output logic                       mem_ctl_oe,
  input  wire logic                  prescaler_clk
);
  import pin_mux_pkg::*;

  state_t s_q;
  state_t s_d;
  logic   req;
  logic   bus_drive;

  // a request is answered one cycle after it is first seen
  assign req       = avm_req.read | avm_req.write;
  // pins may drive while the bus runs, or always if idle drive is set
  assign bus_drive = mem_bus.bus_active | s_q.bus_idle_drive_ctl;

  // outputs straight from the state flops, except waitrequest, which also takes the live request
  assign avm_rsp.waitrequest = req & ~s_q.ack;
  assign avm_rsp.readdata    = s_q.rdata;
  assign portb_line_four_pad = s_q.pb;
  assign portf_pad           = s_q.pf;
  assign dbus_in             = s_q.pf_s2;
  assign mem_ctl_oe          = s_q.mem_ctl_oe;

  // next state: register file, synchronisers and pin muxing
  always_comb begin
    logic [31:0] rd;
    logic        wr_en;
    rd    = '0;
    s_d   = s_q;
    wr_en = avm_req.write & s_q.ack & avm_req.byteenable[0];
    // ack toggles so back-to-back requests each wait one cycle
    s_d.ack = req & ~s_q.ack;

    // write decode; only byte lane 0 holds bits, others are ignored
    if (wr_en) begin
      if (avm_req.address == `OFS_PB_DIR) begin
        s_d.pb_dir = avm_req.writedata[`PB_BIT];
      end else if (avm_req.address == `OFS_PB_DAT) begin
        s_d.pb_dat = avm_req.writedata[`PB_BIT];
      end else if (avm_req.address == `OFS_PB_PERIPH) begin
        s_d.portb_periph_enable = avm_req.writedata[`PB_BIT];
      end else if (avm_req.address == `OFS_PB_PULLUP) begin
        s_d.portb_pullup_enable = avm_req.writedata[`PB_BIT];
      end else if (avm_req.address == `OFS_PF_DIR) begin
        s_d.pf_dir = avm_req.writedata[3:0];
      end else if (avm_req.address == `OFS_PF_DAT) begin
        s_d.pf_dat = avm_req.writedata[3:0];
      end else if (avm_req.address == `OFS_PF_PERIPH) begin
        s_d.pf_periph = avm_req.writedata[3:0];
      end else if (avm_req.address == `OFS_PF_PULLUP) begin
        s_d.portf_pullup_enable = avm_req.writedata[3:0];
      end else if (avm_req.address == `OFS_CLK_SEL) begin
        s_d.clock_out_select = avm_req.writedata[`CLK_SEL_BIT];
      end else if (avm_req.address == `OFS_BUS_CTL) begin
        s_d.bus_idle_drive_ctl = avm_req.writedata[`IDLE_DRIVE_BIT];
      end
    end

    // read decode; unmapped offsets read as zero
    if (avm_req.address == `OFS_PB_DIR) begin
      rd[`PB_BIT] = s_q.pb_dir;
    end else if (avm_req.address == `OFS_PB_DAT) begin
      rd[`PB_BIT] = s_q.pb_dat;
    end else if (avm_req.address == `OFS_PB_PERIPH) begin
      rd[`PB_BIT] = s_q.portb_periph_enable;
    end else if (avm_req.address == `OFS_PB_PULLUP) begin
      rd[`PB_BIT] = s_q.portb_pullup_enable;
    end else if (avm_req.address == `OFS_PF_DIR) begin
      rd[3:0] = s_q.pf_dir;
    end else if (avm_req.address == `OFS_PF_DAT) begin
      rd[3:0] = s_q.pf_dat;
    end else if (avm_req.address == `OFS_PF_PERIPH) begin
      rd[3:0] = s_q.pf_periph;
    end else if (avm_req.address == `OFS_PF_PULLUP) begin
      rd[3:0] = s_q.portf_pullup_enable;
    end else if (avm_req.address == `OFS_CLK_SEL) begin
      rd[`CLK_SEL_BIT] = s_q.clock_out_select;
    end else if (avm_req.address == `OFS_BUS_CTL) begin
      rd[`IDLE_DRIVE_BIT] = s_q.bus_idle_drive_ctl;
    end else if (avm_req.address == `OFS_PIN_IN) begin
      rd[`PB_BIT] = s_q.pb_sync[1];
      rd[3:0]     = s_q.pf_s2;
    end
    // read data is loaded in the first, waiting cycle of a read
    if (avm_req.read & ~s_q.ack) begin
      s_d.rdata = rd;
    end

    // pins come from outside: two flops before any use
    s_d.pb_sync = {s_q.pb_sync[0], portb_line_four_in};
    s_d.pf_s1   = portf_in;
    s_d.pf_s2   = s_q.pf_s1;
    // prescaler is on-chip logic of this clock, one flop keeps output glitch free
    s_d.pclk    = prescaler_clk;

    // port b line: general purpose, clock monitor or top address line
    if (s_q.portb_periph_enable) begin
      s_d.pb.out = s_q.pb_dat;
      s_d.pb.oe  = s_q.pb_dir;
    end else if (s_q.clock_out_select) begin
      s_d.pb.out = s_q.pclk;
      s_d.pb.oe  = 1'b1;
    end else begin
      s_d.pb.out = mem_bus.top_address_line;
      s_d.pb.oe  = bus_drive;
    end
    // pull-up follows its bit alone, even while driving
    s_d.pb.pu = s_q.portb_pullup_enable;

    // memory control pins float with the address line when idle
    s_d.mem_ctl_oe = bus_drive;

    // port f lines: general purpose or data bus bit, each on its own
    for (int i = 0; i < 4; i++) begin
      if (s_q.pf_periph[i]) begin
        s_d.pf[i].out = s_q.pf_dat[i];
        s_d.pf[i].oe  = s_q.pf_dir[i];
      end else begin
        s_d.pf[i].out = mem_bus.dbus_out[i];
        s_d.pf[i].oe  = mem_bus.dbus_wr & bus_drive;
      end
      s_d.pf[i].pu = s_q.portf_pullup_enable[i];
    end

    // synchronous reset: all controls and pins to their defaults
    if (srst) begin
      s_d                     = '0;
      s_d.pb_dir              = `PB_DIR_RST;
      s_d.portb_periph_enable = `PB_PERIPH_RST;
      s_d.portb_pullup_enable = `PB_PULLUP_RST;
      s_d.pf_dir              = `PF_DIR_RST;
      s_d.pf_periph           = `PF_PERIPH_RST;
      s_d.portf_pullup_enable = `PF_PULLUP_RST;
      s_d.clock_out_select    = `CLK_SEL_RST;
      s_d.bus_idle_drive_ctl  = `IDLE_DRIVE_RST;
      s_d.pb.pu               = `PB_PULLUP_RST;
      for (int i = 0; i < 4; i++) begin
        s_d.pf[i].pu = 1'b1;
      end
    end
  end

  // single state register
  always_ff @(posedge mclk) begin
    s_q <= s_d;
  end

  // ---- checks ----
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  // port b line follows its own direction bit in general purpose use
  AST_PB_DIR_OWN: assert property (
    s_q.portb_periph_enable |=> (s_q.pb.oe == $past(s_q.pb_dir))
      && (s_q.pb.out == $past(s_q.pb_dat)))
    else $error("port b line does not follow its direction or data");

  // address line and control pins float on an idle bus without idle drive
  AST_PB_ADDR_IDLE: assert property (
    !s_q.portb_periph_enable && !s_q.clock_out_select && !mem_bus.bus_active
      && !s_q.bus_idle_drive_ctl |=> !s_q.pb.oe && !s_q.mem_ctl_oe)
    else $error("address line driven while bus idle");

  // address line drives the memory address when the bus runs
  AST_PB_ADDR_BUSY: assert property (
    !s_q.portb_periph_enable && !s_q.clock_out_select && mem_bus.bus_active
      |=> s_q.pb.oe && s_q.pb.out == $past(mem_bus.top_address_line))
    else $error("address line not driven during bus activity");

  // clock monitor drives the registered prescaler clock
  AST_PB_CLOCK_OUT: assert property (
    !s_q.portb_periph_enable && s_q.clock_out_select
      |=> s_q.pb.oe && s_q.pb.out == $past(s_q.pclk))
    else $error("clock monitor output wrong");

  // out of reset the line is general purpose and an input
  AST_PB_RESET: assert property (
    disable iff (1'b0)
    $fell(srst) |-> s_q.portb_periph_enable && !s_q.pb_dir
      && s_q.portb_pullup_enable ##1 !s_q.pb.oe)
    else $error("port b line reset state wrong");

  // clock select decides only while the line is not general purpose
  AST_PB_SELECT: assert property (
    s_q.portb_periph_enable && s_q.pb_dir
      |=> s_q.pb.oe && s_q.pb.out == $past(s_q.pb_dat))
    else $error("clock select leaked into general purpose use");

  // port b pull-up enable tracks its bit
  AST_PB_PULLUP: assert property (
    ##1 s_q.pb.pu == $past(s_q.portb_pullup_enable))
    else $error("port b pull-up does not follow its bit");

  // data pins float on an idle bus without idle drive
  AST_PF_IDLE: assert property (
    (s_q.pf_periph == 4'h0) && !mem_bus.bus_active && !s_q.bus_idle_drive_ctl
      |=> (s_q.pf[0].oe | s_q.pf[1].oe | s_q.pf[2].oe | s_q.pf[3].oe) == 1'b0)
    else $error("data pin driven while bus idle");

  // out of reset the data pins are on the data bus with pull-ups on
  AST_PF_RESET: assert property (
    disable iff (1'b0)
    $fell(srst) |-> (s_q.pf_periph == `PF_PERIPH_RST)
      && (s_q.portf_pullup_enable == `PF_PULLUP_RST))
    else $error("port f reset state wrong");

  // each port f line follows its own direction bit
  AST_PF_DIR: assert property (
    s_q.pf_periph == 4'hF
      |=> {s_q.pf[3].oe, s_q.pf[2].oe, s_q.pf[1].oe, s_q.pf[0].oe} == $past(s_q.pf_dir))
    else $error("port f direction wrong");

  // each port f pull-up follows the bit at its own index
  AST_PF_PULLUP: assert property (
    ##1 {s_q.pf[3].pu, s_q.pf[2].pu, s_q.pf[1].pu, s_q.pf[0].pu}
      == $past(s_q.portf_pullup_enable))
    else $error("port f pull-up does not follow its bit");

  // bus answer comes exactly one cycle after the request
  AST_BUS_WAIT: assert property (
    req && avm_rsp.waitrequest |=> !avm_rsp.waitrequest)
    else $error("waitrequest held more than one cycle");

  // memory control pins drive whenever the bus runs or idle drive is set
  AST_MEM_CTL_DRIVE: assert property (
    mem_bus.bus_active || s_q.bus_idle_drive_ctl
      |=> s_q.mem_ctl_oe)
    else $error("memory control pins not driven");

  // idle drive keeps the address line and control pins driven on an idle bus
  AST_PB_IDLE_DRIVE: assert property (
    !s_q.portb_periph_enable && !s_q.clock_out_select && s_q.bus_idle_drive_ctl
      |=> s_q.pb.oe && s_q.mem_ctl_oe)
    else $error("address line floats although idle drive is set");

  // in address use the line carries the address bit, driven or not
  AST_PB_ADDR_VALUE: assert property (
    !s_q.portb_periph_enable && !s_q.clock_out_select
      |=> s_q.pb.out == $past(mem_bus.top_address_line))
    else $error("address line carries the wrong value");

  // a general purpose line set as input never drives
  AST_PB_GPIO_INPUT: assert property (
    s_q.portb_periph_enable && !s_q.pb_dir
      |=> !s_q.pb.oe)
    else $error("port b input line drives the pin");

  // port b pin level passes two flops before it is read
  AST_PB_IN_SYNC: assert property (
    !srst |=> (s_q.pb_sync[0] == $past(portb_line_four_in))
      ##1 (s_q.pb_sync[1] == $past(portb_line_four_in, 2)))
    else $error("port b input synchroniser wrong");

  // data pins drive all four bits in a running write phase
  AST_PF_BUS_DRIVE: assert property (
    (s_q.pf_periph == 4'h0) && mem_bus.dbus_wr && (mem_bus.bus_active || s_q.bus_idle_drive_ctl)
      |=> {s_q.pf[3].oe, s_q.pf[2].oe, s_q.pf[1].oe, s_q.pf[0].oe} == 4'hF)
    else $error("data pins not driven in a write phase");

  // in data bus use the data pins carry the memory data bits
  AST_PF_BUS_VALUE: assert property (
    s_q.pf_periph == 4'h0
      |=> {s_q.pf[3].out, s_q.pf[2].out, s_q.pf[1].out, s_q.pf[0].out}
        == $past(mem_bus.dbus_out))
    else $error("data pins carry the wrong data bits");

  // general purpose data pins present their own data bits
  AST_PF_GPIO_OUT: assert property (
    s_q.pf_periph == 4'hF
      |=> {s_q.pf[3].out, s_q.pf[2].out, s_q.pf[1].out, s_q.pf[0].out}
        == $past(s_q.pf_dat))
    else $error("port f data wrong");

  // port f pin levels pass two flops before they are read
  AST_PF_IN_SYNC: assert property (
    !srst |=> (s_q.pf_s1 == $past(portf_in))
      ##1 (s_q.pf_s2 == $past(portf_in, 2)))
    else $error("port f input synchroniser wrong");

  // out of reset no shared pin drives
  AST_PINS_RESET_FLOAT: assert property (
    disable iff (1'b0)
    $fell(srst) |-> !s_q.pb.oe
      && ({s_q.pf[3].oe, s_q.pf[2].oe, s_q.pf[1].oe, s_q.pf[0].oe} == 4'h0))
    else $error("a shared pin drives out of reset");

  // read data stands until the waiting cycle of the next read ends
  AST_RDATA_HOLD: assert property (
    !(avm_req.read && avm_rsp.waitrequest)
      |=> $stable(avm_rsp.readdata))
    else $error("read data changed without a read");

  // data bus input to the memory logic is the pin level two edges back
  AST_DBUS_IN_SYNC: assert property (
    !srst ##1 !srst
      |=> dbus_in == $past(portf_in, 2))
    else $error("data bus input not synchronised");

  // every new request waits at least its first cycle
  AST_BUS_FIRST_WAIT: assert property (
    $rose(req)
      |-> avm_rsp.waitrequest)
    else $error("request answered in its first cycle");

  // scenarios worth seeing
  COV_CLOCK_OUT: cover property (
    !s_q.portb_periph_enable && s_q.clock_out_select ##1 s_q.pb.oe);
  COV_ADDR_OUT: cover property (
    !s_q.portb_periph_enable && mem_bus.bus_active ##1 s_q.pb.oe);
  COV_PF_GPIO: cover property (
    s_q.pf_periph == 4'hF && s_q.pf_dir != 4'h0);
  COV_READ: cover property (
    avm_req.read && !avm_rsp.waitrequest);
  COV_IDLE_DRIVE: cover property (
    !mem_bus.bus_active && s_q.bus_idle_drive_ctl ##1 s_q.mem_ctl_oe);

endmodule : addr_data_pin_function_mux

// *** src/pin_mux_defines.svh ***
// register offsets, field positions and reset values of the pin mux
`ifndef PIN_MUX_DEFINES_SVH
`define PIN_MUX_DEFINES_SVH
// word-aligned byte offsets on the register bus
`define OFS_PB_DIR      6'h00
`define OFS_PB_DAT      6'h04
`define OFS_PB_PERIPH   6'h08
`define OFS_PB_PULLUP   6'h0C
`define OFS_PF_DIR      6'h10
`define OFS_PF_DAT      6'h14
`define OFS_PF_PERIPH   6'h18
`define OFS_PF_PULLUP   6'h1C
`define OFS_CLK_SEL     6'h20
`define OFS_BUS_CTL     6'h24
`define OFS_PIN_IN      6'h28
// field positions
`define PB_BIT          4
`define CLK_SEL_BIT     0
`define IDLE_DRIVE_BIT  0
// reset values
`define PB_DIR_RST      1'h0
`define PB_PERIPH_RST   1'h1
`define PB_PULLUP_RST   1'h1
`define PF_DIR_RST      4'h0
`define PF_PERIPH_RST   4'h0
`define PF_PULLUP_RST   4'hF
`define CLK_SEL_RST     1'h0
`define IDLE_DRIVE_RST  1'h0
`endif

// *** src/pin_mux_pkg.sv ***
// types shared by the pin mux and its bench
package pin_mux_pkg;
  // register bus request from the master
  typedef struct packed {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } avm_req_t;
  // register bus answer
  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } avm_rsp_t;
  // pad controls of one two-way pin
  typedef struct packed {
    logic out;
    logic oe;
    logic pu;
  } pad_t;
  // request side of the external memory logic
  typedef struct packed {
    logic       bus_active;
    logic       top_address_line;
    logic [3:0] dbus_out;
    logic       dbus_wr;
  } mem_bus_t;
  // whole state of the pin mux
  typedef struct packed {
    logic            pb_dir;
    logic            pb_dat;
    logic            portb_periph_enable;
    logic            portb_pullup_enable;
    logic [3:0]      pf_dir;
    logic [3:0]      pf_dat;
    logic [3:0]      pf_periph;
    logic [3:0]      portf_pullup_enable;
    logic            clock_out_select;
    logic            bus_idle_drive_ctl;
    logic            ack;
    logic [31:0]     rdata;
    logic [1:0]      pb_sync;
    logic [3:0]      pf_s1;
    logic [3:0]      pf_s2;
    logic            pclk;
    pad_t            pb;
    pad_t [3:0]      pf;
    logic            mem_ctl_oe;
  } state_t;
endpackage : pin_mux_pkg

// *** dv/mem_dev_model.sv ***
// pin level model of the external memory devices sitting on the shared pins
`timescale 1ns/1ps
module mem_dev_model (
  // clock
  input  wire logic                    mclk,
  // pad controls from the mux, port b line and four data pins
  input  wire pin_mux_pkg::pad_t       pb_pad,
  input  wire pin_mux_pkg::pad_t [3:0] pf_pad,
  // device drive, bit 4 port b line, bits 3:0 data pins
  input  wire logic [4:0]              dev_oe,
  input  wire logic [4:0]              dev_out,
  // resolved pin levels
  output logic [4:0]                   pin_lvl
);
  import pin_mux_pkg::*;
  pad_t [4:0] pads;
  logic [4:0] last_q;
  assign pads = {pb_pad, pf_pad};
  // a released line without pull-up toggles, so a stale level never passes for a drive
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (pads[i].oe)
        pin_lvl[i] = pads[i].out;
      else if (dev_oe[i])
        pin_lvl[i] = dev_out[i];
      else if (pads[i].pu)
        pin_lvl[i] = 1'b1;
      else
        pin_lvl[i] = ~last_q[i];
    end
  end
  // remembers the last level for the floating case
  always_ff @(posedge mclk) last_q <= pin_lvl;
endmodule : mem_dev_model

// *** dv/tb.sv ***
// self-checking bench of the shared pin function mux
`timescale 1ns/1ps
`include "pin_mux_defines.svh"
module tb;
  import pin_mux_pkg::*;
  logic        mclk, srst, prescaler_clk, mem_ctl_oe;
  avm_req_t    avm_req;
  avm_rsp_t    avm_rsp;
  pad_t        pb_pad;
  pad_t [3:0]  pf_pad;
  pad_t [4:0]  all_pad;
  mem_bus_t    mem_bus;
  logic [3:0]  dbus_in;
  logic [4:0]  pin_lvl, dev_oe, dev_out, e_oe, e_out;
  logic [7:0]  rnd;
  logic [31:0] exp_q[$];
  int          err_count, n_checks;
  logic [5:0]  rofs[10] = '{`OFS_PB_DIR, `OFS_PB_PERIPH, `OFS_PB_PULLUP, `OFS_PF_DIR,
    `OFS_PF_PERIPH, `OFS_PF_PULLUP, `OFS_CLK_SEL, `OFS_BUS_CTL, `OFS_PIN_IN, 6'h2C};
  logic [31:0] rval[10] = '{32'h0000_0000, 32'h0000_0010, 32'h0000_0010, 32'h0000_0000,
    32'h0000_0000, 32'h0000_000F, 32'h0000_0000, 32'h0000_0000, 32'h0000_001F, 32'h0000_0000};
  assign all_pad = {pb_pad, pf_pad};

  addr_data_pin_function_mux DUT (
    .mclk(mclk), .srst(srst), .avm_req(avm_req), .avm_rsp(avm_rsp),
    .portb_line_four_in(pin_lvl[4]), .portb_line_four_pad(pb_pad),
    .portf_in(pin_lvl[3:0]), .portf_pad(pf_pad), .mem_bus(mem_bus),
    .dbus_in(dbus_in), .mem_ctl_oe(mem_ctl_oe), .prescaler_clk(prescaler_clk));
  mem_dev_model u_mem (
    .mclk(mclk), .pb_pad(pb_pad), .pf_pad(pf_pad),
    .dev_oe(dev_oe), .dev_out(dev_out), .pin_lvl(pin_lvl));

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic finish_test();
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  // one transfer held until waitrequest is low; a read notes its expected data
  task automatic bus(input logic rd, input logic [5:0] a, input logic [31:0] d);
    avm_req <= '{read: rd, write: !rd, address: a, byteenable: 4'hF, writedata: rd ? '0 : d};
    if (rd) exp_q.push_back(d);
    do @(posedge mclk); while (avm_rsp.waitrequest !== 1'b0);
    avm_req <= '0;
    @(posedge mclk);
  endtask : bus
  // pad fields judged mid-cycle, bit 4 port b line, bits 3:0 data pins
  task automatic pads(input logic [4:0] oe, input logic [4:0] out, input logic [4:0] pu);
    @(negedge mclk);
    for (int i = 0; i < 5; i++) begin
      check(all_pad[i].oe, oe[i]);
      check(all_pad[i].out, out[i]);
      check(all_pad[i].pu, pu[i]);
    end
    @(posedge mclk);
  endtask : pads

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // read data is taken at the rising edge where waitrequest is seen low
  always @(posedge mclk) begin
    if (avm_req.read && avm_rsp.waitrequest === 1'b0) begin
      if (exp_q.size() == 0)
        check(32'h0000_0001, 32'h0000_0000); // unexpected read result
      else
        check(avm_rsp.readdata, exp_q.pop_front()); // oldest note against the data seen
    end
  end
  // cuts a hang short, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    finish_test();
  end

  initial begin
    srst = 1'b1;
    avm_req = '0;
    mem_bus = '0;
    prescaler_clk = 1'b0;
    dev_oe = '0;
    dev_out = '0;
    rnd = 8'h47;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    pads(5'h00, 5'h00, 5'h1F);
    for (int i = 0; i < 10; i++) bus(1'b1, rofs[i], rval[i]);
    bus(1'b0, 6'h2C, 32'hFFFF_FFFF);
    bus(1'b1, 6'h2C, 32'h0000_0000);
    // software moves the data pins to general purpose and drives random patterns
    bus(1'b0, `OFS_PF_PERIPH, 32'h0000_000F);
    repeat (3) begin
      rnd = lfsr(rnd);
      e_oe = {1'b1, rnd[3:0]};
      e_out = {rnd[4], rnd[7:4]};
      bus(1'b0, `OFS_PB_DIR, 32'h0000_0010);
      bus(1'b0, `OFS_PB_DAT, {27'h0, rnd[4], 4'h0});
      bus(1'b0, `OFS_PF_DIR, {28'h0, rnd[3:0]});
      bus(1'b0, `OFS_PF_DAT, {28'h0, rnd[7:4]});
      pads(e_oe, e_out, 5'h1F);
      bus(1'b1, `OFS_PF_DIR, {28'h0, rnd[3:0]});
    end
    // each pull-up switched off alone
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, `OFS_PB_PULLUP, (i == 4) ? 32'h0000_0000 : 32'h0000_0010);
      bus(1'b0, `OFS_PF_PULLUP, {28'h0, ~(4'h1 << i)});
      pads(e_oe, e_out, ~(5'h01 << i));
    end
    bus(1'b0, `OFS_PB_PULLUP, 32'h0000_0010);
    bus(1'b0, `OFS_PF_PULLUP, 32'h0000_000F);
    // all pins as inputs, levels come from the memory devices
    bus(1'b0, `OFS_PB_DIR, 32'h0000_0000);
    bus(1'b0, `OFS_PF_DIR, 32'h0000_0000);
    rnd = lfsr(rnd);
    dev_oe <= 5'h1F;
    dev_out <= rnd[4:0];
    repeat (3) @(posedge mclk);
    bus(1'b1, `OFS_PIN_IN, {27'h0, rnd[4:0]});
    dev_oe <= 5'h00;
    // peripheral use: address line and data bus, bus state against idle drive
    bus(1'b0, `OFS_PB_PERIPH, 32'h0000_0000);
    bus(1'b0, `OFS_PF_PERIPH, 32'h0000_0000);
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      bus(1'b0, `OFS_BUS_CTL, {31'h0, k[1]});
      mem_bus <= '{bus_active: k[0], top_address_line: rnd[4], dbus_out: rnd[3:0], dbus_wr: 1'b1};
      @(posedge mclk);
      pads({5{k[0] | k[1]}}, rnd[4:0], 5'h1F);
      check(mem_ctl_oe, k[0] | k[1]);
    end
    // bus idle with no drive: the devices answer on the data pins
    bus(1'b0, `OFS_BUS_CTL, 32'h0000_0000);
    mem_bus <= '{bus_active: 1'b0, top_address_line: rnd[4], dbus_out: 4'h0, dbus_wr: 1'b0};
    dev_oe <= 5'h0F;
    dev_out <= ~rnd[4:0];
    repeat (3) @(posedge mclk);
    pads(5'h00, {rnd[4], 4'h0}, 5'h1F);
    check(dbus_in, {28'h0, ~rnd[3:0]});
    dev_oe <= 5'h00;
    // clock monitor on the port b line
    bus(1'b0, `OFS_CLK_SEL, 32'h0000_0001);
    repeat (4) begin
      rnd = lfsr(rnd);
      prescaler_clk <= rnd[0];
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      check(pb_pad.oe, 1'b1);
      check(pb_pad.out, rnd[0]);
      @(posedge mclk);
    end
    // back to general purpose with clock select still set: the select must not leak
    bus(1'b0, `OFS_PB_DIR, 32'h0000_0010);
    bus(1'b0, `OFS_PB_DAT, 32'h0000_0010);
    bus(1'b0, `OFS_PB_PERIPH, 32'h0000_0010);
    pads(5'h10, 5'h10, 5'h1F);
    finish_test();
  end
endmodule : tb
